// ---- verilog/acs_top.sv ----
// converter sequencer top: registers, trigger, result buffer, interrupt
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module acs_top
    import acs_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int BUF_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic sleep_i,
    input wire logic timer_trig_i,
    input wire logic ext_trig_i,
    input wire logic cmp_i,
    output logic [RES_W-1:0] dac_trial_o,
    output logic [3:0] mux_sel_o,
    output logic [1:0] hold_sel_o,
    output logic hold_sample_o,
    output logic vref_ext_o,
    output logic [15:0] pin_digital_o,
    output logic irq_o
);
    logic [15:0] ctrl_one_reg, ctrl_one_next;
    logic [15:0] ctrl_two_reg, ctrl_two_next;
    logic [15:0] ctrl_three_reg, ctrl_three_next;
    logic [15:0] input_select_reg, input_select_next;
    logic [15:0] pin_function_reg, pin_function_next;
    logic [15:0] scan_select_reg, scan_select_next;
    logic [1:0] stat_reg, stat_next;
    logic [1:0] mask_reg, mask_next;
    logic [31:0] rdata_next;
    logic [RES_W-1:0] result_buffer [BUF_DEPTH];
    logic [3:0] wptr_reg, wptr_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] acq_cnt_reg, acq_cnt_next;
    acs_state_e state_reg, state_next;
    logic conv_start;
    logic tick;
    logic sar_busy;
    logic sar_done;
    logic [RES_W-1:0] sar_result;
    logic [RES_W-1:0] trial;
    logic conv_on;
    logic [2:0] trig_src;
    logic wr_one;
    logic irq_next;
    logic [1:0] ev;

    // 16-bit formatted view of a 10-bit entry
    function automatic logic [15:0] fmt(input logic [RES_W-1:0] v,
                                        input logic [1:0] f);
        logic [15:0] r;
        r = 16'h0000;
        unique case (f)
            2'b00: r = {6'b0, v};
            2'b01: r = {{6{~v[RES_W-1]}}, ~v[RES_W-1], v[RES_W-2:0]};
            2'b10: r = {v, 6'b0};
            2'b11: r = {~v[RES_W-1], v[RES_W-2:0], 6'b0};
        endcase
        return r;
    endfunction : fmt

    assign conv_on = ctrl_one_reg[CTRL1_ON_BIT];
    assign trig_src = ctrl_one_reg[CTRL1_TRIG_LSB +: 3];
    assign wr_one = wr_i && addr_i == ADDR_CTRL_ONE;

    // sleep_i only gates the cpu, the sequencer stays clocked
    acs_tad_div #(.DIV_W(6)) u_div (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .run_i(conv_on),
        .div_i(ctrl_three_reg[CTRL3_DIV_LSB +: 6]),
        .tick_o(tick)
    );

    acs_sar_core #(.RES_W(RES_W)) u_sar (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .start_i(conv_start),
        .abort_i(!conv_on),
        .tick_i(tick),
        .cmp_i(cmp_i),
        .trial_o(trial),
        .busy_o(sar_busy),
        .done_o(sar_done),
        .result_o(sar_result)
    );

    // sequencer; auto mode needs no sync tads, giving top rate
    always_comb begin
        state_next = state_reg;
        acq_cnt_next = acq_cnt_reg;
        conv_start = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (conv_on && ctrl_one_reg[CTRL1_SAMPLE_BIT]) begin
                    state_next = ST_ACQ;
                    acq_cnt_next = '0;
                end
            end
            ST_ACQ: begin
                if (tick && trig_src == TRIG_AUTO) begin
                    acq_cnt_next = acq_cnt_reg + 8'd1;
                end
                unique case (trig_src)
                    TRIG_SOFT: begin
                        conv_start = !ctrl_one_reg[CTRL1_SAMPLE_BIT];
                    end
                    TRIG_TIMER: conv_start = timer_trig_i;
                    TRIG_EXT: conv_start = ext_trig_i;
                    TRIG_AUTO: conv_start = tick && (acq_cnt_reg + 8'd1 >=
                        {3'b0, ctrl_three_reg[CTRL3_ACQ_LSB +: 5]});
                    default: conv_start = 1'b0;
                endcase
                if (conv_start) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (!conv_on) begin
            state_next = ST_IDLE;
            conv_start = 1'b0;
        end
    end

    // counting, irq events, register writes
    always_comb begin
        logic done_evt;
        done_evt = 1'b0;
        wptr_next = wptr_reg;
        cnt_next = cnt_reg;
        ctrl_one_next = ctrl_one_reg;
        ctrl_two_next = ctrl_two_reg;
        ctrl_three_next = ctrl_three_reg;
        input_select_next = input_select_reg;
        pin_function_next = pin_function_reg;
        scan_select_next = scan_select_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        ev = 2'b00;
        if (wr_i) begin
            unique case (addr_i)
                ADDR_CTRL_ONE: ctrl_one_next = wdata_i[15:0];
                ADDR_CTRL_TWO: ctrl_two_next = wdata_i[15:0];
                ADDR_CTRL_THREE: ctrl_three_next = wdata_i[15:0];
                ADDR_INPUT_SEL: input_select_next = wdata_i[15:0];
                ADDR_PIN_FUNC: pin_function_next = wdata_i[15:0];
                ADDR_SCAN_SEL: scan_select_next = wdata_i[15:0];
                ADDR_IRQ_MASK: mask_next = wdata_i[1:0];
                default: ;
            endcase
        end
        // a stopped converter restarts filling at entry zero
        if (!conv_on) begin
            wptr_next = '0;
        end
        if (sar_done && conv_on) begin
            wptr_next = wptr_reg + 4'd1;
            if (cnt_reg >= ctrl_two_reg[CTRL2_SPI_LSB +: 4]) begin
                cnt_next = '0;
                wptr_next = '0;
                done_evt = 1'b1;
            end else begin
                cnt_next = cnt_reg + 4'd1;
            end
        end
        // auto mode re-arms sampling; soft mode leaves it clear
        if (sar_done && conv_on && trig_src == TRIG_AUTO) begin
            ctrl_one_next[CTRL1_SAMPLE_BIT] = 1'b1;
        end
        if (ctrl_one_next[CTRL1_ON_BIT] == 1'b0) begin
            cnt_next = '0;
        end
        ev[IRQ_CONV_BIT] = done_evt;
        ev[IRQ_ABORT_BIT] = conv_on && sar_busy && wr_one
            && !wdata_i[CTRL1_ON_BIT];
        if (rd_i && addr_i == ADDR_IRQ_STAT) begin
            stat_next = 2'b00;
        end
        stat_next = stat_next | ev; // set beats read clear
        if (done_evt) begin
            ctrl_one_next[CTRL1_DONE_BIT] = 1'b1;
        end
        irq_next = |(stat_next & mask_reg);
    end

    // register read, formatted buffer read one cycle later
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (rd_i) begin
            if (addr_i >= ADDR_BUF_BASE) begin
                rdata_next[15:0] = fmt(result_buffer[addr_i[5:2]],
                    ctrl_one_reg[CTRL1_FORM_LSB +: 2]);
            end else begin
                unique case (addr_i)
                    ADDR_CTRL_ONE: rdata_next[15:0] = ctrl_one_reg;
                    ADDR_CTRL_TWO: rdata_next[15:0] = ctrl_two_reg;
                    ADDR_CTRL_THREE: rdata_next[15:0] = ctrl_three_reg;
                    ADDR_INPUT_SEL: rdata_next[15:0] = input_select_reg;
                    ADDR_PIN_FUNC: rdata_next[15:0] = pin_function_reg;
                    ADDR_SCAN_SEL: rdata_next[15:0] = scan_select_reg;
                    ADDR_IRQ_STAT: rdata_next[1:0] = stat_reg;
                    ADDR_IRQ_MASK: rdata_next[1:0] = mask_reg;
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // buffer written only by the converter, never by the bus
    always_ff @(posedge clk_i) begin
        if (sar_done && conv_on) begin
            result_buffer[wptr_reg] <= sar_result;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            acq_cnt_reg <= '0;
            wptr_reg <= '0;
            cnt_reg <= '0;
            ctrl_one_reg <= RST_CTRL;
            ctrl_two_reg <= RST_CTRL;
            ctrl_three_reg <= RST_CTRL;
            input_select_reg <= RST_CTRL;
            pin_function_reg <= RST_PIN_FUNC;
            scan_select_reg <= RST_CTRL;
            stat_reg <= 2'b00;
            mask_reg <= 2'b00;
            rdata_o <= 32'h0000_0000;
            irq_o <= 1'b0;
            dac_trial_o <= '0;
            mux_sel_o <= '0;
            hold_sel_o <= '0;
            hold_sample_o <= 1'b0;
            vref_ext_o <= 1'b0;
            pin_digital_o <= 16'h0000;
        end else begin
            state_reg <= state_next;
            acq_cnt_reg <= acq_cnt_next;
            wptr_reg <= wptr_next;
            cnt_reg <= cnt_next;
            ctrl_one_reg <= ctrl_one_next;
            ctrl_two_reg <= ctrl_two_next;
            ctrl_three_reg <= ctrl_three_next;
            input_select_reg <= input_select_next;
            pin_function_reg <= pin_function_next;
            scan_select_reg <= scan_select_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            rdata_o <= rdata_next;
            irq_o <= irq_next;
            dac_trial_o <= trial;
            mux_sel_o <= input_select_reg[3:0];
            hold_sel_o <= input_select_reg[9:8];
            hold_sample_o <= state_next == ST_ACQ;
            vref_ext_o <= ctrl_two_reg[CTRL2_VREF_LSB];
            pin_digital_o <= pin_function_reg;
        end
    end

    chk_irq_follows_stat: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (stat_reg[IRQ_CONV_BIT] && mask_reg[IRQ_CONV_BIT]
         && !(rd_i && addr_i == ADDR_IRQ_STAT)) |=> irq_o)
        else $error("irq not raised for set status");
    chk_acq_start: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (state_reg == ST_IDLE && conv_on && ctrl_one_reg[CTRL1_SAMPLE_BIT])
        |=> state_reg == ST_ACQ || !conv_on)
        else $error("acquisition did not start");
    chk_soft_trig: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (state_reg == ST_ACQ && conv_on && trig_src == TRIG_SOFT
         && !ctrl_one_reg[CTRL1_SAMPLE_BIT]) |=> sar_busy || !conv_on)
        else $error("soft trigger ignored");
    chk_abort_stop: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !conv_on |=> !sar_busy && state_reg == ST_IDLE)
        else $error("abort did not stop");
    chk_done_flag: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(stat_reg[IRQ_CONV_BIT]) |-> $past(sar_done))
        else $error("irq flag without conversion");
    chk_conv_len: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(sar_busy) |-> ##1 !sar_done)
        else $error("conversion ended at once");
    chk_read_zero: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data outside read cycle");
    chk_pin_func: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ##1 pin_digital_o == $past(pin_function_reg))
        else $error("pin function not applied");
endmodule : acs_top
`default_nettype wire

// ---- verilog/acs_pkg.sv ----
// package: register map, fields, reset values and timing for the converter sequencer
package acs_pkg;
    // register word offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADDR_CTRL_THREE = 8'h08;
    localparam logic [7:0] ADDR_INPUT_SEL = 8'h0C;
    localparam logic [7:0] ADDR_PIN_FUNC = 8'h10;
    localparam logic [7:0] ADDR_SCAN_SEL = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_BUF_BASE = 8'h40;
    // control_reg_one fields
    localparam int CTRL1_SAMPLE_BIT = 1;
    localparam int CTRL1_DONE_BIT = 0;
    localparam int CTRL1_TRIG_LSB = 5;
    localparam int CTRL1_FORM_LSB = 8;
    localparam int CTRL1_ON_BIT = 15;
    // control_reg_two fields
    localparam int CTRL2_SPI_LSB = 2;
    localparam int CTRL2_VREF_LSB = 13;
    // control_reg_three fields
    localparam int CTRL3_DIV_LSB = 0;
    localparam int CTRL3_ACQ_LSB = 8;
    // trigger source codes
    localparam logic [2:0] TRIG_SOFT = 3'b000;
    localparam logic [2:0] TRIG_TIMER = 3'b011;
    localparam logic [2:0] TRIG_EXT = 3'b001;
    localparam logic [2:0] TRIG_AUTO = 3'b111;
    // status/mask bits
    localparam int IRQ_CONV_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;
    // reset values
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_PIN_FUNC = 16'h0000;
    // converter timing: 12 conversion clocks plus one to load
    localparam int CONV_TAD = 12;
    // 1 Msps at 250 MHz: 250 cycles per sample
    localparam real CLK_NS = 4.0;
    localparam real SAMPLE_PERIOD_NS = 1000.0;
    localparam int SAMPLE_CYCLES = int'(SAMPLE_PERIOD_NS / CLK_NS);
    // state machine
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10
    } acs_state_e;
endpackage : acs_pkg

// ---- verilog/acs_tad_div.sv ----
// tad divider: one-cycle enable at clk*(div+1)/2 rounding up to whole cycles, never fewer than two
`timescale 1ns/1ns
`default_nettype none
module acs_tad_div
    import acs_pkg::*;
#(
    parameter int DIV_W = 6
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic tick_o
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic tick_next;
    logic [DIV_W-1:0] top;

    // half-cycle steps cannot be made on one clock; round up
    always_comb begin
        top = div_i >> 1;
        // comparator answers two cycles after a trial; one-cycle tad is stale
        if (top == '0) begin
            top = DIV_W'(1);
        end
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (!run_i) begin
            cnt_next = '0;
        end else if (cnt_reg >= top) begin
            cnt_next = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o <= tick_next;
        end
    end
endmodule : acs_tad_div
`default_nettype wire

// ---- verilog/acs_sar_core.sv ----
// successive-approximation sequencer: two settle tad ticks, then one result bit per tick
`timescale 1ns/1ns
`default_nettype none
module acs_sar_core
    import acs_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic tick_i,
    input wire logic cmp_i,
    output logic [RES_W-1:0] trial_o,
    output logic busy_o,
    output logic done_o,
    output logic [RES_W-1:0] result_o
);
    logic [RES_W-1:0] sar_reg;
    logic [RES_W-1:0] sar_next;
    logic [RES_W-1:0] bit_reg;
    logic [RES_W-1:0] bit_next;
    logic [3:0] tad_reg;
    logic [3:0] tad_next;
    logic busy_next;
    logic done_next;
    logic [RES_W-1:0] res_next;

    assign trial_o = sar_reg | bit_reg;

    // two settle tads then ten decision tads: 12 total
    always_comb begin
        sar_next = sar_reg;
        bit_next = bit_reg;
        tad_next = tad_reg;
        busy_next = busy_o;
        done_next = 1'b0;
        res_next = result_o;
        if (abort_i) begin
            busy_next = 1'b0;
        end else if (start_i && !busy_o) begin
            busy_next = 1'b1;
            sar_next = '0;
            bit_next = {1'b1, {(RES_W-1){1'b0}}};
            tad_next = '0;
        end else if (busy_o && tick_i) begin
            tad_next = tad_reg + 4'd1;
            if (tad_reg >= 4'(CONV_TAD - RES_W)) begin
                if (cmp_i) begin
                    sar_next = sar_reg | bit_reg;
                end
                bit_next = bit_reg >> 1;
                if (bit_reg[0]) begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    res_next = cmp_i ? (sar_reg | bit_reg) : sar_reg;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sar_reg <= '0;
            bit_reg <= '0;
            tad_reg <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            result_o <= '0;
        end else begin
            sar_reg <= sar_next;
            bit_reg <= bit_next;
            tad_reg <= tad_next;
            busy_o <= busy_next;
            done_o <= done_next;
            result_o <= res_next;
        end
    end
endmodule : acs_sar_core
`default_nettype wire

// ---- tb/acs_analog_model.sv ----
// analog side model: sixteen fixed input levels, hold and comparator
`timescale 1ns/1ns
`default_nettype none
module acs_analog_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] mux_sel_i,
    input wire logic hold_sample_i,
    input wire logic vref_ext_i,
    input wire logic [9:0] trial_i,
    output logic cmp_o
);
    logic [9:0] held_reg;

    // input n sits at 0x3d*n+0x11 against the supply pair
    function automatic logic [9:0] acs_level(input logic [3:0] n,
                                             input logic ext);
        logic [9:0] v;
        v = 10'(10'h03d * n + 10'h011);
        // pin reference spans twice the supply pair
        return ext ? v >> 1 : v;
    endfunction : acs_level

    // hold tracks the routed input only while sampling
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            held_reg <= 10'h000;
        end else if (hold_sample_i) begin
            held_reg <= acs_level(mux_sel_i, vref_ext_i);
        end
    end

    assign cmp_o = (held_reg >= trial_i);
endmodule : acs_analog_model
`default_nettype wire

// ---- tb/acs_top_tb.sv ----
// testbench for the converter sequencer: register tasks, conversion runs
`timescale 1ns/1ns
`default_nettype none
module acs_top_tb
    import acs_pkg::*;
();
    localparam int CONV_WAIT = 4 * CONV_TAD + 16;
    logic clk_i, rstn_i, wr_i, rd_i, sleep_i, timer_trig_i, ext_trig_i;
    logic cmp, hold, vref, irq;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata;
    logic [9:0] trial;
    logic [3:0] mux;
    logic [1:0] hold_sel;
    logic [15:0] pin_dig;
    int miscompares, checks, cycles, n;
    logic [7:0] regs [5] = '{ADDR_CTRL_TWO, ADDR_CTRL_THREE, ADDR_INPUT_SEL,
                             ADDR_PIN_FUNC, ADDR_SCAN_SEL};
    logic [15:0] vals [5] = '{16'h203c, 16'h0102, 16'h0305, 16'ha5a5,
                              16'hffff};

    acs_top i_acs_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
        .sleep_i(sleep_i), .timer_trig_i(timer_trig_i),
        .ext_trig_i(ext_trig_i), .cmp_i(cmp), .dac_trial_o(trial),
        .mux_sel_o(mux), .hold_sel_o(hold_sel), .hold_sample_o(hold),
        .vref_ext_o(vref), .pin_digital_o(pin_dig), .irq_o(irq));
    acs_analog_model i_acs_analog_model (.clk_i(clk_i), .rstn_i(rstn_i),
        .mux_sel_i(mux), .hold_sample_i(hold), .vref_ext_i(vref),
        .trial_i(trial), .cmp_o(cmp));

    function automatic logic [9:0] lvl(input int i, input logic ext);
        logic [9:0] v;
        v = 10'(10'h03d * i + 10'h011);
        return ext ? v >> 1 : v;
    endfunction : lvl

    function automatic logic [31:0] fmt(input logic [9:0] v, input int f);
        logic [9:0] s;
        s = v ^ 10'h200;
        case (f)
            0: return {22'h00_0000, v};
            1: return {16'h0000, {6{s[9]}}, s};
            2: return {16'h0000, v, 6'h00};
            default: return {16'h0000, s, 6'h00};
        endcase
    endfunction : fmt

    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= {16'h0000, d};
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk32(rdata, exp);
    endtask : chk_rd

    // lets a register write reach the level output
    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic wait_irq(output int k);
        k = 0;
        while (irq !== 1'b1 && k < 1000) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        if (k == 1000) begin
            miscompares++;
        end
    endtask : wait_irq

    // one sample: hold, fire the chosen trigger, then drop sample_request
    task automatic conv(input logic [2:0] t, input logic [3:0] inp);
        wr(ADDR_INPUT_SEL, {12'h000, inp});
        wr(ADDR_CTRL_ONE, 16'h8002 | (16'(t) << CTRL1_TRIG_LSB));
        repeat (8) @(posedge clk_i);
        timer_trig_i <= (t == TRIG_TIMER);
        ext_trig_i <= (t == TRIG_EXT);
        @(posedge clk_i);
        timer_trig_i <= 1'b0;
        ext_trig_i <= 1'b0;
        wr(ADDR_CTRL_ONE, 16'h8000 | (16'(t) << CTRL1_TRIG_LSB));
        repeat (CONV_WAIT) @(posedge clk_i);
    endtask : conv

    task automatic count_run(input logic [3:0] spi);
        logic [2:0] trig [3];
        trig = '{TRIG_SOFT, TRIG_EXT, TRIG_TIMER};
        wr(ADDR_CTRL_ONE, 16'h0000);
        wr(ADDR_CTRL_TWO, 16'(spi) << CTRL2_SPI_LSB);
        for (int i = 0; i <= spi; i++) begin
            #1 chk_bit(irq, 1'b0);
            conv(trig[i % 3], 4'(i));
        end
        wait_irq(n);
        chk_bit(irq, 1'b1);
        for (int i = 0; i <= spi; i++) begin
            chk_rd(ADDR_BUF_BASE + 8'(4 * i),
                   {22'h00_0000, lvl(i, 1'b0)});
        end
        chk_rd(ADDR_CTRL_ONE,
               32'h0000_8001 | (32'(trig[spi % 3]) << CTRL1_TRIG_LSB));
        chk_rd(ADDR_IRQ_STAT, 32'h0000_0001);
    endtask : count_run

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        {rstn_i, wr_i, rd_i, sleep_i, timer_trig_i, ext_trig_i} = 6'h00;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        chk_rd(ADDR_CTRL_ONE, {16'h0000, RST_CTRL});
        chk_rd(ADDR_PIN_FUNC, {16'h0000, RST_PIN_FUNC});
        chk_rd(8'h30, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            wr(regs[i], vals[i]);
            chk_rd(regs[i], {16'h0000, vals[i]});
        end
        chk_bit(vref, 1'b1);
        chk32({16'h0000, pin_dig}, 32'h0000_a5a5);
        chk32({26'h000_0000, hold_sel, mux}, 32'h0000_0035);
        // single soft conversion in sleep against the pin reference
        wr(ADDR_CTRL_TWO, 16'h2000);
        wr(ADDR_IRQ_MASK, 16'h0001);
        sleep_i <= 1'b1;
        wr(ADDR_CTRL_ONE, 16'h8002);
        repeat (8) @(posedge clk_i);
        wr(ADDR_CTRL_ONE, 16'h8000);
        wait_irq(n);
        chk_bit(n <= SAMPLE_CYCLES, 1'b1);
        chk_bit(irq, 1'b1);
        repeat (20) @(posedge clk_i);
        #1;
        chk_bit(irq, 1'b1);
        wr(ADDR_IRQ_MASK, 16'h0000);
        settle();
        chk_bit(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 16'h0001);
        settle();
        chk_bit(irq, 1'b1);
        chk_rd(ADDR_BUF_BASE, {22'h00_0000, lvl(5, 1'b1)});
        chk_rd(ADDR_CTRL_ONE, 32'h0000_8001);
        chk_rd(ADDR_IRQ_STAT, 32'h0000_0001);
        settle();
        chk_bit(irq, 1'b0);
        chk_rd(ADDR_IRQ_STAT, 32'h0000_0000);
        sleep_i <= 1'b0;
        // software write must not reach the buffer; then every format
        wr(ADDR_BUF_BASE, 16'hffff);
        for (int f = 0; f < 4; f++) begin
            wr(ADDR_CTRL_ONE, 16'(f) << CTRL1_FORM_LSB);
            chk_rd(ADDR_BUF_BASE, fmt(lvl(5, 1'b1), f));
        end
        count_run(4'h2);
        count_run(4'hf);
        // abort mid-conversion: buffer entry 0 keeps its earlier input 0 result
        wr(ADDR_INPUT_SEL, 16'h000f);
        wr(ADDR_CTRL_ONE, 16'h8002);
        repeat (8) @(posedge clk_i);
        wr(ADDR_CTRL_ONE, 16'h8000);
        repeat (6) @(posedge clk_i);
        wr(ADDR_CTRL_ONE, 16'h0000);
        repeat (CONV_WAIT) @(posedge clk_i);
        chk_rd(ADDR_IRQ_STAT, 32'h0000_0002);
        chk_rd(ADDR_BUF_BASE, {22'h00_0000, lvl(0, 1'b0)});
        // auto trigger after the programmed sample time
        wr(ADDR_CTRL_TWO, 16'h0000);
        wr(ADDR_INPUT_SEL, 16'h0009);
        wr(ADDR_CTRL_ONE, 16'h80e2);
        wait_irq(n);
        wr(ADDR_CTRL_ONE, 16'h0000);
        chk_rd(ADDR_BUF_BASE, {22'h00_0000, lvl(9, 1'b0)});
        finish_test();
    end
endmodule : acs_top_tb
`default_nettype wire
